/* core/pvc_regs.sv */
// Operation
// [R1] Config bit 15 bypasses 4B/5B encoder and 5B/4B decoder; resets to 0.
// [R2] Config bit 14 bypasses scrambler and descrambler; resets to 0.
// [R3] Config bit 13 bypasses descrambler, alignment, symbol coder and scrambler.
// [R4] Config bit 12 forces signal detect active; debug only; resets to 0.
// [R5] Config bit 10 selects 100BASE-TX operation; resets to 1.
// [R6] Software writes 0 to reserved bits 11, 8, 6 and 5.
// [R7] Config bit 7 forces good 100 Mb/s link status; resets to 0.
// [R8] Config bit 4 enables automatic reduced power-down; resets to 1.
// [R9] Writing 1 to bit 3 resets all PHY state machines, then self-clears.
// [R10] Config bit 2 turns management preamble suppression on; resets to 1.
// [R11] Writing 1 to bit 1 enters sleep, all but clocks powered down.
// [R12] Leaving sleep keeps prior configuration but resets state machines.
// [R13] Config bit 0 loops received data out to transmit; resets to 0.
// [R14] Status bit 15 shows resolved 100 Mb/s full duplex; default 1.
// [R15] Status bit 14 shows resolved 100 Mb/s half duplex; default 1.
// [R16] Status bits 15..12 show resolved mode; meaningless without auto-negotiation.
// [R17] Config bit 9 is reserved and always reads 0.
// [R18] Registers sit at management indices 16 and 17.
//
// The Wishbone interface to the registers was left to the implementer.
module pvc_regs (
  input  wire logic        ref_clk_i,                   // 200 MHz clock
  input  wire logic        sys_rst_i,                   // Async reset, high
  input  wire logic        wb_cyc_i,                    // Wishbone cycle
  input  wire logic        wb_stb_i,                    // Wishbone strobe
  input  wire logic        wb_we_i,                     // Write enable
  input  wire logic [pvc_pkg::PVC_ADDR_W-1:0] wb_adr_i, // Byte address
  input  wire logic [3:0]  wb_sel_i,                    // Byte lanes
  input  wire logic [31:0] wb_dat_i,                    // Write data
  output logic      [31:0] wb_dat_o,                    // Read data
  output logic             wb_ack_o,                    // Acknowledge
  input  wire logic        an_done_i,                   // Auto-neg result valid
  input  wire logic [3:0]  an_mode_i,                   // Resolved mode 100F,100H,10F,10H
  input  wire logic        signal_detect_i,             // Raw line signal detect
  input  wire logic        link_100_i,                  // Raw 100M link status
  output logic             coder_bypass_o,              // Bypass 4B/5B coder
  output logic             scrambler_bypass_o,          // Bypass scrambler
  output logic             symbol_align_bypass_o,       // Bypass alignment path
  output logic             signal_detect_o,             // Effective signal detect
  output logic             tx_mode_o,                   // 100BASE-TX select
  output logic             link_100_o,                  // Effective 100M link
  output logic             auto_reduced_powerdown_en_o, // Reduced power-down enable
  output logic             mgmt_preamble_suppress_o,    // Preamble suppression
  output logic             sleep_o,                     // Sleep power-down
  output logic             remote_loop_out_o,           // Remote loop-out
  output logic             fsm_soft_reset_o             // PHY state machine reset
);
  import pvc_pkg::*;

  typedef struct packed {
    logic [15:0] cfg;
    logic [3:0]  res;
    logic [31:0] rdat;
    logic        ack;
    logic        sd_m;
    logic        sd;
    logic        lk_m;
    logic        lk;
  } pvc_state_t;

  pvc_state_t s_q;
  pvc_state_t s_d;
  pvc_rst_if  rst_if ();

  logic        acc;
  logic        fsm_rst_set;
  logic        hit_cfg;
  logic        hit_sts;
  logic [15:0] wval;
  logic [15:0] sts;

  pvc_rst_gen u_rst_gen (
    .ref_clk_i (ref_clk_i),
    .sys_rst_i (sys_rst_i),
    .rst_if    (rst_if)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  assign acc     = wb_cyc_i & wb_stb_i & ~s_q.ack;
  assign hit_cfg = (wb_adr_i == PVC_ADDR_CONFIG); // [R18]
  assign hit_sts = (wb_adr_i == PVC_ADDR_STATUS); // [R18]
  // Only a 1 actually written on lane 0 requests a reset; a stored 1 merged
  // in from an untouched lane must not retrigger it
  assign fsm_rst_set = acc & wb_we_i & hit_cfg & wb_sel_i[0] & wb_dat_i[PVC_B_FSM_RST]; // [R9]

  always_comb begin
    wval = s_q.cfg;
    if (wb_sel_i[0]) begin
      wval[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      wval[15:8] = wb_dat_i[15:8];
    end
  end

  // Bits 11..0 of status lie outside this block and read as zero
  assign sts = {s_q.res, 12'h000}; // [R16]

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    s_d      = s_q;
    s_d.ack  = acc;
    s_d.sd_m = signal_detect_i;
    s_d.sd   = s_q.sd_m;
    s_d.lk_m = link_100_i;
    s_d.lk   = s_q.lk_m;
    // Mode result only updates once negotiation reports done
    if (an_done_i) begin
      s_d.res = an_mode_i; // [R14] [R15]
    end
    if (acc && wb_we_i && hit_cfg) begin
      // Reserved bits 11,8,6,5 are stored as written; software keeps them 0
      s_d.cfg = wval & PVC_CONFIG_WMASK; // [R6] [R17]
    end
    // Bit 3 is set only by a written 1 and cleared only by completion;
    // the set wins, so a request landing on the done cycle is kept
    s_d.cfg[PVC_B_FSM_RST] = fsm_rst_set | (s_q.cfg[PVC_B_FSM_RST] & ~rst_if.done); // [R9]
    s_d.rdat = 32'h0000_0000;
    if (acc && !wb_we_i) begin
      if (hit_cfg) begin
        s_d.rdat = {16'h0000, s_q.cfg};
      end else if (hit_sts) begin
        s_d.rdat = {16'h0000, sts};
      end
    end
  end

  // Start reset on a write of bit 3, or on wake from sleep
  always_comb begin
    rst_if.start = 1'b0;
    if (acc && wb_we_i && hit_cfg) begin
      if (fsm_rst_set) begin
        rst_if.start = 1'b1; // [R9]
      end
      if (s_q.cfg[PVC_B_SLEEP] && !wval[PVC_B_SLEEP]) begin
        rst_if.start = 1'b1; // [R12]
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q      <= '0;
      s_q.cfg  <= PVC_CONFIG_RST; // [R5] [R8] [R10]
      s_q.res  <= PVC_RES_RST;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign wb_ack_o                    = s_q.ack;
  assign wb_dat_o                    = s_q.rdat;
  assign coder_bypass_o              = s_q.cfg[PVC_B_CODER_BYP];    // [R1]
  assign scrambler_bypass_o          = s_q.cfg[PVC_B_SCR_BYP];      // [R2]
  assign symbol_align_bypass_o       = s_q.cfg[PVC_B_ALIGN_BYP];    // [R3]
  assign signal_detect_o             = s_q.cfg[PVC_B_FORCE_SD] | s_q.sd;  // [R4]
  assign tx_mode_o                   = s_q.cfg[PVC_B_TX_MODE];      // [R5]
  assign link_100_o                  = s_q.cfg[PVC_B_FORCE_LINK] | s_q.lk; // [R7]
  assign auto_reduced_powerdown_en_o = s_q.cfg[PVC_B_ARPD_EN];      // [R8]
  assign mgmt_preamble_suppress_o    = s_q.cfg[PVC_B_PREAMBLE_SUP]; // [R10]
  // Configuration is never cleared by sleep, so it is intact on wake
  assign sleep_o                     = s_q.cfg[PVC_B_SLEEP];        // [R11] [R12]
  assign remote_loop_out_o           = s_q.cfg[PVC_B_LOOP_OUT];     // [R13]
  assign fsm_soft_reset_o            = rst_if.busy;                 // [R9]
endmodule

/* core/pvc_pkg.sv */
package pvc_pkg;
  // Register indices (PHY register numbers); byte address is index times four
  localparam logic [7:0]  PVC_IDX_CONFIG     = 8'h10;
  localparam logic [7:0]  PVC_IDX_STATUS     = 8'h11;
  localparam logic [7:0]  PVC_ADDR_CONFIG    = 8'h40;
  localparam logic [7:0]  PVC_ADDR_STATUS    = 8'h44;
  localparam int          PVC_ADDR_W         = 8;
  // Configuration field positions
  localparam int          PVC_B_CODER_BYP    = 15;
  localparam int          PVC_B_SCR_BYP      = 14;
  localparam int          PVC_B_ALIGN_BYP    = 13;
  localparam int          PVC_B_FORCE_SD     = 12;
  localparam int          PVC_B_RSV11        = 11;
  localparam int          PVC_B_TX_MODE      = 10;
  localparam int          PVC_B_RSV9         = 9;
  localparam int          PVC_B_RSV8         = 8;
  localparam int          PVC_B_FORCE_LINK   = 7;
  localparam int          PVC_B_RSV6         = 6;
  localparam int          PVC_B_RSV5         = 5;
  localparam int          PVC_B_ARPD_EN      = 4;
  localparam int          PVC_B_FSM_RST      = 3;
  localparam int          PVC_B_PREAMBLE_SUP = 2;
  localparam int          PVC_B_SLEEP        = 1;
  localparam int          PVC_B_LOOP_OUT     = 0;
  // Status field positions
  localparam int          PVC_B_RES_100FD    = 15;
  localparam int          PVC_B_RES_100HD    = 14;
  localparam int          PVC_B_RES_10FD     = 13;
  localparam int          PVC_B_RES_10HD     = 12;
  // Reset values and masks
  localparam logic [15:0] PVC_CONFIG_RST     = 16'h0414;
  localparam logic [15:0] PVC_CONFIG_WMASK   = 16'hFDFF;
  localparam logic [3:0]  PVC_RES_RST        = 4'hF;
  // Soft reset pulse length in cycles
  localparam int          PVC_FSM_RST_CYC    = 16;
  localparam logic [4:0]  PVC_FSM_RST_LAST   = 5'(PVC_FSM_RST_CYC - 1);
endpackage

/* core/pvc_rst_if.sv */
interface pvc_rst_if;
  logic start;
  logic busy;
  logic done;
  modport ctl (output start, input busy, input done);
  modport gen (input start, output busy, output done);
endinterface

/* core/pvc_rst_gen.sv */
module pvc_rst_gen (
  input  wire logic ref_clk_i,  // Clock
  input  wire logic sys_rst_i,  // Async reset
  pvc_rst_if.gen    rst_if      // Start / busy / done
);
  import pvc_pkg::*;

  typedef enum logic [0:0] {
    PVC_RG_IDLE = 1'b0,
    PVC_RG_RUN  = 1'b1
  } pvc_rg_state_t;

  typedef struct packed {
    pvc_rg_state_t st;
    logic [4:0]    cnt;
    logic          done;
  } pvc_rg_t;

  pvc_rg_t s_q;
  pvc_rg_t s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    case (s_q.st)
      PVC_RG_IDLE: begin
        if (rst_if.start) begin
          s_d.st  = PVC_RG_RUN;
          s_d.cnt = 5'h0;
        end
      end
      PVC_RG_RUN: begin
        if (rst_if.start) begin
          // A request while busy restarts the full pulse rather than being lost
          s_d.cnt = 5'h0;
        end else if (s_q.cnt == PVC_FSM_RST_LAST) begin
          s_d.st   = PVC_RG_IDLE;
          s_d.done = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 5'h1;
        end
      end
      default: s_d.st = PVC_RG_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rst_if.busy = (s_q.st == PVC_RG_RUN);
  assign rst_if.done = s_q.done;
endmodule

/* dv/pvc_regs_sva.sv */
module pvc_regs_sva
  import pvc_pkg::*;
(
  input wire logic        ref_clk_i,        // Clock
  input wire logic        sys_rst_i,        // Reset
  input wire logic        wb_cyc_i,         // Cycle
  input wire logic        wb_stb_i,         // Strobe
  input wire logic        wb_we_i,          // Write
  input wire logic [pvc_pkg::PVC_ADDR_W-1:0] wb_adr_i, // Address
  input wire logic [3:0]  wb_sel_i,         // Lanes
  input wire logic [31:0] wb_dat_i,         // Write data
  input wire logic [31:0] wb_dat_o,         // Read data
  input wire logic        wb_ack_o,         // Ack
  input wire logic        coder_bypass_o,   // Coder bypass
  input wire logic        signal_detect_o,  // Signal detect
  input wire logic        link_100_o,       // Link
  input wire logic        sleep_o,          // Sleep
  input wire logic        fsm_soft_reset_o  // Soft reset
);
  logic       wr;
  logic       srst_go;
  logic [4:0] since_q;
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & !wb_ack_o & (wb_adr_i == PVC_ADDR_CONFIG);
  // Reset requests: a 1 written to bit 3, or leaving sleep
  assign srst_go = wr & wb_sel_i[0]
                 & (wb_dat_i[PVC_B_FSM_RST] | (sleep_o & !wb_dat_i[PVC_B_SLEEP]));
  // Cycles since the last request; saturates so it never wraps back into range
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      since_q <= 5'h1F;
    end else if (srst_go) begin
      since_q <= 5'h00;
    end else if (since_q != 5'h1F) begin
      since_q <= since_q + 5'h01;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Judged after ack, when the master has released the bus
  property p_fld(b, o);
    wr && wb_sel_i[b/8] |-> ##2 o == $past(wb_dat_i[b], 2);
  endproperty
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_BIT9: assert property (wb_ack_o |-> !wb_dat_o[9])
    else $error("bit 9 set");
  AST_CODER: assert property (p_fld(15, coder_bypass_o))
    else $error("coder bypass");
  AST_SLEEP: assert property (p_fld(1, sleep_o))
    else $error("sleep");
  AST_FORCE_SD: assert property (wr && wb_sel_i[1] && wb_dat_i[12] |-> ##2 signal_detect_o)
    else $error("forced detect");
  AST_FORCE_LINK: assert property (wr && wb_sel_i[0] && wb_dat_i[7] |-> ##2 link_100_o)
    else $error("forced link");
  AST_SRST: assert property (wr && wb_sel_i[0] && wb_dat_i[3] |-> ##[1:3] fsm_soft_reset_o)
    else $error("no soft reset");
  // High exactly for the fixed count after the latest request, retrigger included
  AST_SRST_LEN: assert property (fsm_soft_reset_o == (since_q <= PVC_FSM_RST_LAST))
    else $error("reset length");
  AST_WAKE: assert property ($fell(sleep_o) |-> ##[0:3] fsm_soft_reset_o)
    else $error("wake reset");
  cover property (wr && wb_dat_i[3]);
  cover property ($fell(sleep_o));
  cover property (wb_ack_o && !wb_we_i);
endmodule

bind pvc_regs pvc_regs_sva chk_u (
  .ref_clk_i        (ref_clk_i),
  .sys_rst_i        (sys_rst_i),
  .wb_cyc_i         (wb_cyc_i),
  .wb_stb_i         (wb_stb_i),
  .wb_we_i          (wb_we_i),
  .wb_adr_i         (wb_adr_i),
  .wb_sel_i         (wb_sel_i),
  .wb_dat_i         (wb_dat_i),
  .wb_dat_o         (wb_dat_o),
  .wb_ack_o         (wb_ack_o),
  .coder_bypass_o   (coder_bypass_o),
  .signal_detect_o  (signal_detect_o),
  .link_100_o       (link_100_o),
  .sleep_o          (sleep_o),
  .fsm_soft_reset_o (fsm_soft_reset_o)
);

/* dv/pvc_phy_model.sv */
module pvc_phy_model (
  input  wire logic       ref_clk_i,  // Clock
  input  wire logic       fsm_rst_i,  // State machine reset
  input  wire logic       neg_i,      // Negotiation running
  input  wire logic [3:0] mode_i,     // Mode to resolve
  output logic            an_done_o,  // Result valid
  output logic      [3:0] an_mode_o   // Resolved mode
);
  timeunit 1ns;
  timeprecision 100ps;
  // A soft reset restarts negotiation; idle mode lines carry garbage
  always @(posedge ref_clk_i) begin
    an_done_o <= neg_i & !fsm_rst_i;
    an_mode_o <= neg_i ? mode_i : ~mode_i;
  end
endmodule

/* dv/pvc_regs_tb_top.sv */
module pvc_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import pvc_pkg::*;
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
  logic        ref_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, neg = 1'b0, sd = 1'b0, lk = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0, mode = 4'h0, an_mode;
  logic [31:0] wdat = 32'h0000_0000, rdat;
  logic        ack, an_done;
  logic [15:0] q;
  wire  [15:0] o;
  int          n_fail = 0, num_checks = 0, cycles = 0;
  pvc_regs dut_u (.ref_clk_i, .sys_rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .an_done_i(an_done), .an_mode_i(an_mode), .signal_detect_i(sd), .link_100_i(lk),
    .coder_bypass_o(o[15]), .scrambler_bypass_o(o[14]), .symbol_align_bypass_o(o[13]),
    .signal_detect_o(o[12]), .tx_mode_o(o[10]), .link_100_o(o[7]), .sleep_o(o[1]),
    .auto_reduced_powerdown_en_o(o[4]), .mgmt_preamble_suppress_o(o[2]),
    .remote_loop_out_o(o[0]), .fsm_soft_reset_o(o[3]));
  pvc_phy_model phy_u (.ref_clk_i, .fsm_rst_i(o[3]), .neg_i(neg), .mode_i(mode),
    .an_done_o(an_done), .an_mode_o(an_mode));
  always #2.5 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      results();
    end
  end
  task automatic results();
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, 16'h0000, d};
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[15:0];
    {cyc, stb, we} <= 3'b000;
    if (n == 20) n_fail++;
  endtask
  task automatic t_reset();
    bus(0, PVC_ADDR_CONFIG, 16'h0000, 4'h3);
    `CHK(q, 16'h0414)
    bus(0, PVC_ADDR_STATUS, 16'h0000, 4'h3);
    `CHK(q, 16'hF000)
    `CHK(o & 16'hF497, 16'h0414)
  endtask
  task automatic t_cfg();
    bus(1, PVC_ADDR_CONFIG, 16'hF695, 4'h3);
    `CHK(o & 16'hF497, 16'hF495)
    bus(0, PVC_ADDR_CONFIG, 16'h0000, 4'h3);
    `CHK(q, 16'hF495)
    bus(1, PVC_ADDR_CONFIG, 16'h0014, 4'h1);
    bus(0, PVC_ADDR_CONFIG, 16'h0000, 4'h3);
    `CHK(q, 16'hF414)
    bus(1, PVC_ADDR_CONFIG, 16'h0414, 4'h3);
  endtask
  task automatic t_srst();
    int n;
    n = 0;
    bus(1, PVC_ADDR_CONFIG, 16'h041C, 4'h1);
    repeat (40) begin
      n += int'(o[3] === 1'b1);
      @(posedge ref_clk_i);
    end
    `CHK(n, PVC_FSM_RST_CYC)
    bus(0, PVC_ADDR_CONFIG, 16'h0000, 4'h3);
    `CHK(q, 16'h0414)
    bus(1, PVC_ADDR_CONFIG, 16'h041C, 4'h1);
    bus(0, PVC_ADDR_CONFIG, 16'h0000, 4'h3);
    `CHK(q, 16'h041C)
    // A request while busy restarts the full pulse from its own write
    bus(1, PVC_ADDR_CONFIG, 16'h041C, 4'h1);
    n = 0;
    repeat (40) begin
      n += int'(o[3] === 1'b1);
      @(posedge ref_clk_i);
    end
    `CHK(n, PVC_FSM_RST_CYC)
    bus(0, PVC_ADDR_CONFIG, 16'h0000, 4'h3);
    `CHK(q, 16'h0414)
  endtask
  task automatic t_sleep();
    bus(1, PVC_ADDR_CONFIG, 16'h8416, 4'h3);
    `CHK(o[1], 1'b1)
    bus(1, PVC_ADDR_CONFIG, 16'h0414, 4'h1);
    bus(0, PVC_ADDR_CONFIG, 16'h0000, 4'h3);
    `CHK(q, 16'h8414)
    `CHK(o[3], 1'b1)
    repeat (30) @(posedge ref_clk_i);
    bus(1, PVC_ADDR_CONFIG, 16'h0414, 4'h3);
  endtask
  task automatic t_sts();
    {neg, mode} <= 5'h14;
    repeat (4) @(posedge ref_clk_i);
    bus(0, PVC_ADDR_STATUS, 16'h0000, 4'h3);
    `CHK(q, 16'h4000)
    mode <= 4'h8;
    repeat (4) @(posedge ref_clk_i);
    bus(0, PVC_ADDR_STATUS, 16'h0000, 4'h3);
    `CHK(q, 16'h8000)
    {neg, sd, lk} <= 3'b011;
    repeat (4) @(posedge ref_clk_i);
    bus(0, PVC_ADDR_STATUS, 16'h0000, 4'h3);
    `CHK(q, 16'h8000)
    `CHK({o[12], o[7]}, 2'b11)
    bus(1, 8'h48, 16'hFFFF, 4'h3);
    bus(0, 8'h48, 16'h0000, 4'h3);
    `CHK(q, 16'h0000)
  endtask
  initial begin
    repeat (20) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_cfg();
    t_srst();
    t_sleep();
    t_sts();
    results();
  end
endmodule
